// >>> hdl/cpu_addr_unit.sv
`timescale 1ns/1ps
module cpu_addr_unit (
	// clock and reset
	input  wire logic                        mclk,
	input  wire logic                        sys_rst,
	// special register access
	input  wire addr_ptr_pkg::sfr_req_type   sfr_req,
	output logic                [7:0]        sfr_rdata_q,
	// single-bit access
	input  wire logic                        bit_wr,
	input  wire logic           [7:0]        bit_addr,
	input  wire logic                        bit_val,
	// core stack and status
	input  wire logic                        push_req,
	input  wire logic                        pop_req,
	input  wire logic           [7:0]        acc_in,
	input  wire logic                        psw_upd,
	input  wire logic           [7:0]        psw_in,
	input  wire logic                        aux_upd,
	input  wire logic           [7:0]        aux_in,
	// core pointer and move requests
	input  wire logic                        data_ptr0_inc,
	input  wire logic                        data_ptr0_use,
	input  wire logic                        movx_data_ptr0,
	input  wire logic                        movx_ri,
	input  wire logic           [7:0]        ri_val,
	input  wire logic           [7:0]        port2_latch,
	// interrupt progress and clock
	input  wire logic                        hi_prio_active,
	input  wire logic                        lo_prio_active,
	input  wire logic                        osc_32m,
	// program fetch
	input  wire logic                        fetch_req,
	output logic                             fetch_done,
	output logic                             fetch_busy,
	// internal RAM stack port
	output logic                [15:0]       iram_addr_q,
	output logic                [7:0]        iram_wdata_q,
	output logic                             iram_wr_q,
	output logic                             iram_rd_q,
	// external RAM move port
	output logic                [23:0]       xram_addr_q,
	output logic                             xram_strobe_q,
	// decoded control
	output logic                [15:0]       vec_base_q,
	output logic                [4:0]        bank_base_q,
	output logic                [7:0]        xram_page_base_q,
	output logic                             flat_mode_q,
	output logic                [7:0]        psw_q,
	output logic                [7:0]        aux_q
);
	logic [7:0]  sp_q;
	logic [7:0]  esp_q;
	logic [7:0]  wait_q;
	logic [7:0]  amode_q;
	logic [7:0]  psel_q;
	logic [7:0]  ri_page_q;
	logic [7:0]  ri_top_q;
	logic [23:0] ptr0;
	logic [23:0] ptr1;
	logic [23:0] sel_ptr;
	logic [15:0] sp16;
	logic [15:0] stk_inc;
	logic [15:0] stk_dec;
	logic [15:0] stk_cur;
	logic        flat;
	logic        sel;
	logic        ptr_used;
	logic        wr_en;
	logic [7:0]  rd_d;

	assign wr_en    = sfr_req.wr;
	assign flat     = amode_q[addr_ptr_pkg::AM_HI_BIT];
	assign sel      = psel_q[addr_ptr_pkg::PS_SEL_BIT];
	assign sel_ptr  = sel ? ptr1 : ptr0;
	assign ptr_used = data_ptr0_inc | data_ptr0_use | movx_data_ptr0;
	assign sp16     = {esp_q, sp_q};
	assign stk_inc  = flat ? sp16 + 16'h0001 : {8'h00, sp_q + 8'h01};
	assign stk_dec  = flat ? sp16 - 16'h0001 : {8'h00, sp_q - 8'h01};
	assign stk_cur  = flat ? sp16 : {8'h00, sp_q};

	// stack pointers
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sp_q  <= addr_ptr_pkg::RST_ZERO;
			esp_q <= addr_ptr_pkg::RST_ZERO;
		end else begin
			if (push_req) begin
				{esp_q, sp_q} <= {flat ? stk_inc[15:8] : esp_q, stk_inc[7:0]};
			end else if (pop_req) begin
				{esp_q, sp_q} <= {flat ? stk_dec[15:8] : esp_q, stk_dec[7:0]};
			end
			if (wr_en && sfr_req.addr == addr_ptr_pkg::SFR_SP) begin
				sp_q <= sfr_req.wdata;
			end
			if (wr_en && sfr_req.addr == addr_ptr_pkg::SFR_ESP) begin
				esp_q <= sfr_req.wdata;
			end
		end
	end

	// internal RAM stack access
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			iram_addr_q  <= 16'h0000;
			iram_wdata_q <= 8'h00;
			iram_wr_q    <= 1'b0;
			iram_rd_q    <= 1'b0;
		end else begin
			iram_wr_q <= push_req;
			iram_rd_q <= pop_req & ~push_req;
			if (push_req) begin
				iram_addr_q  <= stk_inc;
				iram_wdata_q <= acc_in;
			end else if (pop_req) begin
				iram_addr_q <= stk_cur;
			end
		end
	end

	// configuration registers
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wait_q           <= addr_ptr_pkg::RST_WAIT;
			amode_q          <= addr_ptr_pkg::RST_ZERO;
			xram_page_base_q <= addr_ptr_pkg::RST_ZERO;
			ri_page_q        <= addr_ptr_pkg::RST_ZERO;
			ri_top_q         <= addr_ptr_pkg::RST_ZERO;
		end else if (wr_en) begin
			case (sfr_req.addr)
				addr_ptr_pkg::SFR_WAIT: begin
					wait_q <= sfr_req.wdata & addr_ptr_pkg::WAIT_MASK;
				end
				addr_ptr_pkg::SFR_AMODE: begin
					amode_q <= sfr_req.wdata & addr_ptr_pkg::AMODE_MASK;
				end
				addr_ptr_pkg::SFR_XBASE: begin
					xram_page_base_q <= sfr_req.wdata;
				end
				addr_ptr_pkg::SFR_RI_PAGE: begin
					ri_page_q <= sfr_req.wdata;
				end
				addr_ptr_pkg::SFR_RI_TOP: begin
					ri_top_q <= sfr_req.wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// status word and auxiliary register
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			psw_q <= addr_ptr_pkg::RST_ZERO;
			aux_q <= addr_ptr_pkg::RST_ZERO;
		end else begin
			if (psw_upd) begin
				psw_q <= psw_in;
			end
			if (aux_upd) begin
				aux_q <= aux_in;
			end
			if (bit_wr && bit_addr[7:3] == addr_ptr_pkg::BIT_PSW_BASE) begin
				psw_q[bit_addr[2:0]] <= bit_val;
			end
			if (bit_wr && bit_addr[7:3] == addr_ptr_pkg::BIT_AUX_BASE) begin
				aux_q[bit_addr[2:0]] <= bit_val;
			end
			if (wr_en && sfr_req.addr == addr_ptr_pkg::SFR_PSW) begin
				psw_q <= sfr_req.wdata;
			end
			if (wr_en && sfr_req.addr == addr_ptr_pkg::SFR_AUX) begin
				aux_q <= sfr_req.wdata;
			end
		end
	end

	// pointer selection
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			psel_q <= addr_ptr_pkg::RST_ZERO;
		end else if (wr_en && sfr_req.addr == addr_ptr_pkg::SFR_PSEL) begin
			psel_q <= sfr_req.wdata & addr_ptr_pkg::PSEL_MASK;
		end else if (ptr_used && psel_q[addr_ptr_pkg::PS_TOG_BIT]) begin
			psel_q[addr_ptr_pkg::PS_SEL_BIT] <= ~sel;
		end
	end

	data_ptr_unit #(.WIDTH(24)) u_ptr0 (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.wr_lo     (wr_en && sfr_req.addr == addr_ptr_pkg::SFR_P0_LO),
		.wr_hi     (wr_en && sfr_req.addr == addr_ptr_pkg::SFR_P0_HI),
		.wr_top    (wr_en && sfr_req.addr == addr_ptr_pkg::SFR_P0_TOP),
		.wdata     (sfr_req.wdata),
		.step      (data_ptr0_inc && !sel),
		.step_down (psel_q[addr_ptr_pkg::PS_DIR0_BIT]),
		.flat      (flat),
		.ptr_q     (ptr0)
	);

	data_ptr_unit #(.WIDTH(24)) u_ptr1 (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.wr_lo     (wr_en && sfr_req.addr == addr_ptr_pkg::SFR_P1_LO),
		.wr_hi     (wr_en && sfr_req.addr == addr_ptr_pkg::SFR_P1_HI),
		.wr_top    (wr_en && sfr_req.addr == addr_ptr_pkg::SFR_P1_TOP),
		.wdata     (sfr_req.wdata),
		.step      (data_ptr0_inc && sel),
		.step_down (psel_q[addr_ptr_pkg::PS_DIR1_BIT]),
		.flat      (flat),
		.ptr_q     (ptr1)
	);

	// external RAM move addresses
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			xram_addr_q   <= 24'h000000;
			xram_strobe_q <= 1'b0;
		end else begin
			xram_strobe_q <= movx_data_ptr0 | movx_ri;
			if (movx_data_ptr0) begin
				xram_addr_q <= sel_ptr;
			end else if (movx_ri) begin
				xram_addr_q[23:16] <= ri_top_q;
				xram_addr_q[15:8]  <= amode_q[addr_ptr_pkg::AM_PAGE_BIT] ? ri_page_q
					: port2_latch;
				xram_addr_q[7:0]   <= ri_val;
			end
		end
	end

	// decoded mode outputs
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			vec_base_q  <= addr_ptr_pkg::VEC_NORMAL;
			bank_base_q <= 5'h00;
			flat_mode_q <= 1'b0;
		end else begin
			vec_base_q  <= amode_q[addr_ptr_pkg::AM_VEC_BIT] ? addr_ptr_pkg::VEC_RELOC
				: addr_ptr_pkg::VEC_NORMAL;
			bank_base_q <= {psw_q[addr_ptr_pkg::PSW_BANK_LO +: 2], 3'b000};
			flat_mode_q <= flat;
		end
	end

	flash_wait_gen u_wait (
		.mclk         (mclk),
		.sys_rst      (sys_rst),
		.fetch_req    (fetch_req),
		.wait_cfg     (wait_q[3:0]),
		.osc_32m      (osc_32m),
		.fetch_done_q (fetch_done),
		.fetch_busy_q (fetch_busy)
	);

	// register read mux
	always_comb begin
		rd_d = 8'h00;
		case (sfr_req.addr)
			addr_ptr_pkg::SFR_SP:      rd_d = sp_q;
			addr_ptr_pkg::SFR_P0_LO:   rd_d = ptr0[7:0];
			addr_ptr_pkg::SFR_P0_HI:   rd_d = ptr0[15:8];
			addr_ptr_pkg::SFR_P1_LO:   rd_d = ptr1[7:0];
			addr_ptr_pkg::SFR_P1_HI:   rd_d = ptr1[15:8];
			addr_ptr_pkg::SFR_PSEL:    rd_d = psel_q;
			addr_ptr_pkg::SFR_WAIT:    rd_d = wait_q;
			addr_ptr_pkg::SFR_P0_TOP:  rd_d = ptr0[23:16];
			addr_ptr_pkg::SFR_P1_TOP:  rd_d = ptr1[23:16];
			addr_ptr_pkg::SFR_ESP:     rd_d = esp_q;
			addr_ptr_pkg::SFR_AMODE: begin
				rd_d = amode_q;
				rd_d[addr_ptr_pkg::AM_SA_BIT] = flat;
			end
			addr_ptr_pkg::SFR_IPFLAGS: begin
				rd_d[addr_ptr_pkg::IP_HI_BIT] = hi_prio_active;
				rd_d[addr_ptr_pkg::IP_LO_BIT] = lo_prio_active;
			end
			addr_ptr_pkg::SFR_XBASE:   rd_d = xram_page_base_q;
			addr_ptr_pkg::SFR_PSW:     rd_d = psw_q;
			addr_ptr_pkg::SFR_RI_PAGE: rd_d = ri_page_q;
			addr_ptr_pkg::SFR_RI_TOP:  rd_d = ri_top_q;
			addr_ptr_pkg::SFR_AUX:     rd_d = aux_q;
			default:                   rd_d = 8'h00;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sfr_rdata_q <= 8'h00;
		end else if (sfr_req.rd) begin
			sfr_rdata_q <= rd_d;
		end
	end

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	push_addr_a: assert property (push_req && !flat |=> iram_wr_q
		&& iram_addr_q == {8'h00, $past(sp_q) + 8'h01} && iram_wdata_q == $past(acc_in))
		else $error("push address wrong");
	pop_addr_a: assert property (pop_req && !push_req && !flat
		|=> iram_rd_q && iram_addr_q == {8'h00, $past(sp_q)})
		else $error("pop address wrong");
	flat_stack_a: assert property (push_req && flat && !wr_en
		|=> iram_addr_q == $past(sp16) + 16'h0001 && sp16 == iram_addr_q)
		else $error("flat stack wrong");
	wait_rst_a: assert property ($past(sys_rst) && !sys_rst
		|-> wait_q == addr_ptr_pkg::RST_WAIT)
		else $error("wait reset wrong");
	wait_three_a: assert property (fetch_req && !fetch_busy && wait_q == 8'h03
		|=> !fetch_done [*3] ##1 fetch_done)
		else $error("three waits wrong");
	wait_force_a: assert property (fetch_req && !fetch_busy && wait_q == 8'h00 && osc_32m
		|=> !fetch_done ##1 fetch_done)
		else $error("forced wait wrong");
	vec_base_a: assert property (##1 vec_base_q
		== ($past(amode_q[addr_ptr_pkg::AM_VEC_BIT]) ? 16'h3000 : 16'h0000))
		else $error("vector base wrong");
	ri_addr_a: assert property (movx_ri && !movx_data_ptr0 |=> xram_strobe_q
		&& xram_addr_q == {$past(ri_top_q), ($past(amode_q[addr_ptr_pkg::AM_PAGE_BIT])
		? $past(ri_page_q) : $past(port2_latch)), $past(ri_val)})
		else $error("indirect address wrong");
	ptr_addr_a: assert property (movx_data_ptr0 |=> xram_addr_q == $past(sel_ptr))
		else $error("pointer address wrong");
	toggle_a: assert property (ptr_used && psel_q[addr_ptr_pkg::PS_TOG_BIT]
		&& !(wr_en && sfr_req.addr == addr_ptr_pkg::SFR_PSEL) |=> sel != $past(sel))
		else $error("toggle missed");
	large_top_a: assert property (data_ptr0_inc && !flat && !wr_en
		|=> ptr0[23:16] == $past(ptr0[23:16]) && ptr1[23:16] == $past(ptr1[23:16]))
		else $error("top byte moved");
	step_dir_a: assert property (data_ptr0_inc && !sel && psel_q[addr_ptr_pkg::PS_DIR0_BIT]
		&& flat && !wr_en |=> ptr0 == $past(ptr0) - 24'h000001)
		else $error("decrement wrong");
	step_dir1_a: assert property (data_ptr0_inc && sel && psel_q[addr_ptr_pkg::PS_DIR1_BIT]
		&& flat && !wr_en |=> ptr1 == $past(ptr1) - 24'h000001)
		else $error("pointer one decrement wrong");
	sa_read_a: assert property (sfr_req.rd && sfr_req.addr == addr_ptr_pkg::SFR_AMODE
		|=> sfr_rdata_q[addr_ptr_pkg::AM_SA_BIT] == $past(flat))
		else $error("stack flag wrong");

	flat_push_c: cover property (flat && push_req ##1 pop_req);
	long_wait_c: cover property (fetch_req && !fetch_busy && wait_q == 8'h0f);
	toggle_c: cover property (movx_data_ptr0 && psel_q[addr_ptr_pkg::PS_TOG_BIT] ##1 movx_data_ptr0);
	ri_page_c: cover property (movx_ri && amode_q[addr_ptr_pkg::AM_PAGE_BIT]);
endmodule

// >>> hdl/addr_ptr_pkg.sv
package addr_ptr_pkg;
	// special register offsets
	localparam logic [7:0] SFR_SP       = 8'h81;
	localparam logic [7:0] SFR_P0_LO    = 8'h82;
	localparam logic [7:0] SFR_P0_HI    = 8'h83;
	localparam logic [7:0] SFR_P1_LO    = 8'h84;
	localparam logic [7:0] SFR_P1_HI    = 8'h85;
	localparam logic [7:0] SFR_PSEL     = 8'h86;
	localparam logic [7:0] SFR_WAIT     = 8'h92;
	localparam logic [7:0] SFR_P0_TOP   = 8'h93;
	localparam logic [7:0] SFR_P1_TOP   = 8'h95;
	localparam logic [7:0] SFR_ESP      = 8'h9b;
	localparam logic [7:0] SFR_AMODE    = 8'h9d;
	localparam logic [7:0] SFR_IPFLAGS  = 8'hc5;
	localparam logic [7:0] SFR_XBASE    = 8'hc6;
	localparam logic [7:0] SFR_PSW      = 8'hd0;
	localparam logic [7:0] SFR_RI_PAGE  = 8'hda;
	localparam logic [7:0] SFR_RI_TOP   = 8'hea;
	localparam logic [7:0] SFR_AUX      = 8'hf0;
	// bit-addressable base addresses
	localparam logic [4:0] BIT_PSW_BASE = 5'h1a;
	localparam logic [4:0] BIT_AUX_BASE = 5'h1e;
	// reset values
	localparam logic [7:0] RST_ZERO     = 8'h00;
	localparam logic [7:0] RST_WAIT     = 8'h07;
	// writable masks and field positions
	localparam logic [7:0] WAIT_MASK    = 8'h0f;
	localparam logic [7:0] AMODE_MASK   = 8'h2b;
	localparam logic [7:0] PSEL_MASK    = 8'he1;
	localparam int         AM_VEC_BIT   = 5;
	localparam int         AM_PAGE_BIT  = 3;
	localparam int         AM_SA_BIT    = 2;
	localparam int         AM_HI_BIT    = 1;
	localparam int         PS_DIR1_BIT  = 7;
	localparam int         PS_DIR0_BIT  = 6;
	localparam int         PS_TOG_BIT   = 5;
	localparam int         PS_SEL_BIT   = 0;
	localparam int         IP_HI_BIT    = 2;
	localparam int         IP_LO_BIT    = 1;
	localparam int         PSW_BANK_LO  = 3;
	// vector regions
	localparam logic [15:0] VEC_NORMAL  = 16'h0000;
	localparam logic [15:0] VEC_RELOC   = 16'h3000;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sfr_req_type;
endpackage

// >>> hdl/data_ptr_unit.sv
`timescale 1ns/1ps
module data_ptr_unit #(
	parameter int WIDTH = 24
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             sys_rst,
	// byte writes
	input  wire logic             wr_lo,
	input  wire logic             wr_hi,
	input  wire logic             wr_top,
	input  wire logic [7:0]       wdata,
	// stepping
	input  wire logic             step,
	input  wire logic             step_down,
	input  wire logic             flat,
	// pointer value
	output logic      [WIDTH-1:0] ptr_q
);
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ptr_q <= '0;
		end else begin
			if (step && flat) begin
				ptr_q <= step_down ? ptr_q - 1'b1 : ptr_q + 1'b1;
			end else if (step) begin
				ptr_q[15:0] <= step_down ? ptr_q[15:0] - 16'h0001 : ptr_q[15:0] + 16'h0001;
			end
			if (wr_lo) begin
				ptr_q[7:0] <= wdata;
			end
			if (wr_hi) begin
				ptr_q[15:8] <= wdata;
			end
			if (wr_top) begin
				ptr_q[WIDTH-1:16] <= wdata;
			end
		end
	end
endmodule

// >>> hdl/flash_wait_gen.sv
`timescale 1ns/1ps
module flash_wait_gen (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	// fetch handshake
	input  wire logic       fetch_req,
	input  wire logic [3:0] wait_cfg,
	input  wire logic       osc_32m,
	output logic            fetch_done_q,
	output logic            fetch_busy_q
);
	typedef enum logic [1:0] {
		W_IDLE  = 2'b01,
		W_COUNT = 2'b10
	} wait_state_type;
	wait_state_type state_q;
	logic [3:0]     cnt_q;
	logic [3:0]     eff_wait;
	assign eff_wait = (wait_cfg == 4'h0 && osc_32m) ? 4'h1 : wait_cfg;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_q      <= W_IDLE;
			cnt_q        <= 4'h0;
			fetch_done_q <= 1'b0;
			fetch_busy_q <= 1'b0;
		end else begin
			fetch_done_q <= 1'b0;
			case (state_q)
				W_IDLE: begin
					if (fetch_req && eff_wait == 4'h0) begin
						fetch_done_q <= 1'b1;
					end else if (fetch_req) begin
						cnt_q        <= eff_wait;
						state_q      <= W_COUNT;
						fetch_busy_q <= 1'b1;
					end
				end
				W_COUNT: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h1) begin
						fetch_done_q <= 1'b1;
						fetch_busy_q <= 1'b0;
						state_q      <= W_IDLE;
					end
				end
				default: begin
					state_q      <= W_IDLE;
					fetch_busy_q <= 1'b0;
				end
			endcase
		end
	end
endmodule

// >>> sim/cpu_addr_unit_bench.sv
`timescale 1ns/1ps
module cpu_addr_unit_bench;
	// clock, reset and stimulus
	logic                      mclk;
	logic                      sys_rst;
	logic [9:0]                strobes;
	addr_ptr_pkg::sfr_req_type req;
	logic [7:0]                bit_addr;
	logic [7:0]                acc_in;
	logic [7:0]                psw_in;
	logic [7:0]                aux_in;
	logic [7:0]                ri_val;
	logic [7:0]                port2_latch;
	logic                      bit_val;
	logic                      hi_prio_active;
	logic                      lo_prio_active;
	logic                      osc_32m;
	// observed outputs
	logic [7:0]                sfr_rdata_q;
	logic [7:0]                psw_q;
	logic [7:0]                aux_q;
	logic [7:0]                xram_page_base_q;
	logic [7:0]                iram_wdata_q;
	logic [15:0]               iram_addr_q;
	logic [15:0]               vec_base_q;
	logic [23:0]               xram_addr_q;
	logic [4:0]                bank_base_q;
	logic                      fetch_done;
	logic                      fetch_busy;
	logic                      iram_wr_q;
	logic                      iram_rd_q;
	logic                      xram_strobe_q;
	logic                      flat_mode_q;
	int                        n_fail;
	int                        checks;

	localparam logic [7:0] regs [18] = '{addr_ptr_pkg::SFR_SP, addr_ptr_pkg::SFR_P0_LO,
		addr_ptr_pkg::SFR_P0_HI, addr_ptr_pkg::SFR_P1_LO, addr_ptr_pkg::SFR_P1_HI,
		addr_ptr_pkg::SFR_PSEL, addr_ptr_pkg::SFR_WAIT, addr_ptr_pkg::SFR_P0_TOP,
		addr_ptr_pkg::SFR_P1_TOP, addr_ptr_pkg::SFR_ESP, addr_ptr_pkg::SFR_AMODE,
		addr_ptr_pkg::SFR_IPFLAGS, addr_ptr_pkg::SFR_XBASE, addr_ptr_pkg::SFR_PSW,
		addr_ptr_pkg::SFR_RI_PAGE, addr_ptr_pkg::SFR_RI_TOP, addr_ptr_pkg::SFR_AUX, 8'h87};
	localparam logic [7:0] masks [18] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'he1, 8'h0f,
		8'hff, 8'hff, 8'hff, 8'h2f, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
	localparam logic [3:0] waits [4] = '{4'h0, 4'h1, 4'h3, 4'hf};

	cpu_addr_unit cpu_addr_unit_inst (
		.mclk             (mclk),
		.sys_rst          (sys_rst),
		.sfr_req          (req),
		.sfr_rdata_q      (sfr_rdata_q),
		.bit_wr           (strobes[6]),
		.bit_addr         (bit_addr),
		.bit_val          (bit_val),
		.push_req         (strobes[0]),
		.pop_req          (strobes[1]),
		.acc_in           (acc_in),
		.psw_upd          (strobes[7]),
		.psw_in           (psw_in),
		.aux_upd          (strobes[8]),
		.aux_in           (aux_in),
		.data_ptr0_inc         (strobes[2]),
		.data_ptr0_use         (strobes[3]),
		.movx_data_ptr0        (strobes[4]),
		.movx_ri          (strobes[5]),
		.ri_val           (ri_val),
		.port2_latch      (port2_latch),
		.hi_prio_active   (hi_prio_active),
		.lo_prio_active   (lo_prio_active),
		.osc_32m          (osc_32m),
		.fetch_req        (strobes[9]),
		.fetch_done       (fetch_done),
		.fetch_busy       (fetch_busy),
		.iram_addr_q      (iram_addr_q),
		.iram_wdata_q     (iram_wdata_q),
		.iram_wr_q        (iram_wr_q),
		.iram_rd_q        (iram_rd_q),
		.xram_addr_q      (xram_addr_q),
		.xram_strobe_q    (xram_strobe_q),
		.vec_base_q       (vec_base_q),
		.bank_base_q      (bank_base_q),
		.xram_page_base_q (xram_page_base_q),
		.flat_mode_q      (flat_mode_q),
		.psw_q            (psw_q),
		.aux_q            (aux_q)
	);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic print_verdict();
		if (n_fail == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic cmp(input string name, input logic [23:0] exp, input logic [23:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		req.addr = a;
		req.wdata = d;
		req.wr = 1'b1;
		@(negedge mclk);
		req.wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge mclk);
		req.addr = a;
		req.rd = 1'b1;
		@(negedge mclk);
		req.rd = 1'b0;
		cmp($sformatf("sfr %h", a), {16'h0, exp}, {16'h0, sfr_rdata_q});
	endtask

	task automatic pulse(input int i);
		@(negedge mclk);
		strobes[i] = 1'b1;
		@(negedge mclk);
		strobes[i] = 1'b0;
	endtask

	// pointer move, observes the selected 24-bit pointer
	task automatic move(input logic [23:0] exp);
		pulse(4);
		cmp("move strobe", 24'h1, {23'h0, xram_strobe_q});
		cmp("move addr", exp, xram_addr_q);
	endtask

	task automatic setp(input logic sel, input logic [23:0] v);
		wr(sel ? addr_ptr_pkg::SFR_P1_LO : addr_ptr_pkg::SFR_P0_LO, v[7:0]);
		wr(sel ? addr_ptr_pkg::SFR_P1_HI : addr_ptr_pkg::SFR_P0_HI, v[15:8]);
		wr(sel ? addr_ptr_pkg::SFR_P1_TOP : addr_ptr_pkg::SFR_P0_TOP, v[23:16]);
	endtask

	task automatic fetch(input logic [3:0] n);
		int k;
		k = 0;
		@(negedge mclk);
		strobes[9] = 1'b1;
		@(negedge mclk);
		strobes[9] = 1'b0;
		cmp("fetch busy", {23'h0, n != 4'h0}, {23'h0, fetch_busy});
		while (fetch_done !== 1'b1 && k < 40) begin
			@(negedge mclk);
			k++;
		end
		cmp("fetch wait", {20'h0, n}, k[23:0]);
	endtask

	initial begin
		#200000;
		n_fail++;
		print_verdict();
	end

	initial begin
		n_fail = 0;
		checks = 0;
		strobes = '0;
		req = '0;
		{bit_addr, acc_in, psw_in, aux_in, ri_val, port2_latch} = '0;
		{bit_val, hi_prio_active, lo_prio_active, osc_32m} = '0;
		sys_rst = 1'b1;
		repeat (6) @(negedge mclk);
		sys_rst = 1'b0;
		fetch(4'h7);
		for (int i = 0; i < 18; i++) begin
			rd(regs[i], (regs[i] == addr_ptr_pkg::SFR_WAIT) ? 8'h07 : 8'h00);
		end
		for (int i = 0; i < 18; i++) wr(regs[i], 8'hff);
		for (int i = 0; i < 18; i++) rd(regs[i], masks[i]);
		cmp("vec base", 24'h003000, {8'h0, vec_base_q});
		cmp("flat", 24'h1, {23'h0, flat_mode_q});
		cmp("xram base", 24'hff, {16'h0, xram_page_base_q});
		cmp("bank", 24'h18, {19'h0, bank_base_q});
		cmp("aux", 24'hff, {16'h0, aux_q});
		for (int i = 0; i < 18; i++) wr(regs[i], 8'h00);
		cmp("vec base", 24'h0, {8'h0, vec_base_q});
		cmp("flat", 24'h0, {23'h0, flat_mode_q});
		wr(addr_ptr_pkg::SFR_AMODE, 8'h01);
		cmp("flat", 24'h0, {23'h0, flat_mode_q});
		rd(addr_ptr_pkg::SFR_AMODE, 8'h01);
		wr(addr_ptr_pkg::SFR_AMODE, 8'h02);
		rd(addr_ptr_pkg::SFR_AMODE, 8'h06);
		wr(addr_ptr_pkg::SFR_AMODE, 8'h00);
		hi_prio_active = 1'b1;
		rd(addr_ptr_pkg::SFR_IPFLAGS, 8'h04);
		hi_prio_active = 1'b0;
		lo_prio_active = 1'b1;
		rd(addr_ptr_pkg::SFR_IPFLAGS, 8'h02);
		lo_prio_active = 1'b0;
		// wait table, then zero promoted in 32MHz range
		foreach (waits[i]) begin
			wr(addr_ptr_pkg::SFR_WAIT, {4'h0, waits[i]});
			fetch(waits[i]);
		end
		osc_32m = 1'b1;
		wr(addr_ptr_pkg::SFR_WAIT, 8'h00);
		fetch(4'h1);
		osc_32m = 1'b0;
		// stack, large then flat
		wr(addr_ptr_pkg::SFR_SP, 8'h07);
		acc_in = 8'h55;
		pulse(0);
		cmp("push wr", 24'h1, {23'h0, iram_wr_q});
		cmp("push addr", 24'h0008, {8'h0, iram_addr_q});
		cmp("push data", 24'h55, {16'h0, iram_wdata_q});
		rd(addr_ptr_pkg::SFR_SP, 8'h08);
		pulse(1);
		cmp("pop rd", 24'h1, {23'h0, iram_rd_q});
		cmp("pop addr", 24'h0008, {8'h0, iram_addr_q});
		rd(addr_ptr_pkg::SFR_SP, 8'h07);
		wr(addr_ptr_pkg::SFR_AMODE, 8'h02);
		wr(addr_ptr_pkg::SFR_SP, 8'hff);
		wr(addr_ptr_pkg::SFR_ESP, 8'h12);
		pulse(1);
		cmp("pop addr", 24'h12ff, {8'h0, iram_addr_q});
		pulse(0);
		cmp("push addr", 24'h12ff, {8'h0, iram_addr_q});
		wr(addr_ptr_pkg::SFR_AMODE, 8'h00);
		// register-indirect moves, then one pointer move
		ri_val = 8'h10;
		port2_latch = 8'h12;
		pulse(5);
		cmp("ri addr", 24'h001210, xram_addr_q);
		wr(addr_ptr_pkg::SFR_RI_TOP, 8'hab);
		wr(addr_ptr_pkg::SFR_RI_PAGE, 8'h34);
		wr(addr_ptr_pkg::SFR_AMODE, 8'h08);
		pulse(5);
		cmp("ri addr", 24'hab3410, xram_addr_q);
		setp(1'b0, 24'h332211);
		move(24'h332211);
		// pointer stepping
		wr(addr_ptr_pkg::SFR_AMODE, 8'h00);
		setp(1'b0, 24'h33ffff);
		pulse(2);
		move(24'h330000);
		wr(addr_ptr_pkg::SFR_AMODE, 8'h02);
		setp(1'b0, 24'h33ffff);
		pulse(2);
		move(24'h340000);
		wr(addr_ptr_pkg::SFR_PSEL, 8'h40);
		pulse(2);
		move(24'h33ffff);
		setp(1'b1, 24'h050000);
		wr(addr_ptr_pkg::SFR_PSEL, 8'h81);
		pulse(2);
		move(24'h04ffff);
		rd(addr_ptr_pkg::SFR_PSEL, 8'h81);
		wr(addr_ptr_pkg::SFR_AMODE, 8'h00);
		wr(addr_ptr_pkg::SFR_PSEL, 8'h40);
		pulse(2);
		move(24'h33fffe);
		wr(addr_ptr_pkg::SFR_PSEL, 8'ha1);
		pulse(3);
		rd(addr_ptr_pkg::SFR_PSEL, 8'ha0);
		move(24'h33fffe);
		rd(addr_ptr_pkg::SFR_PSEL, 8'ha1);
		// single-bit and core updates
		bit_addr = 8'hd3;
		bit_val = 1'b1;
		pulse(6);
		@(negedge mclk);
		cmp("bank", 24'h08, {19'h0, bank_base_q});
		bit_addr = 8'hf7;
		pulse(6);
		cmp("aux", 24'h80, {16'h0, aux_q});
		psw_in = 8'h10;
		pulse(7);
		@(negedge mclk);
		cmp("bank", 24'h10, {19'h0, bank_base_q});
		cmp("psw", 24'h10, {16'h0, psw_q});
		aux_in = 8'h5a;
		pulse(8);
		cmp("aux", 24'h5a, {16'h0, aux_q});
		print_verdict();
	end
endmodule
